// >>> src/iopr_pkg.sv
/*
 * Constants of the I/O port pin remap block: register map, reset values,
 * unlock keys, remap codes and the unlock sequencer states.
 * Assumes a classic Wishbone slave with 32-bit data and byte addresses.
 */
package iopr_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [9:0] OFS_DIRECTION = 10'h000;
   localparam logic [9:0] OFS_LATCH = 10'h004;
   localparam logic [9:0] OFS_LEVEL = 10'h008;
   localparam logic [9:0] OFS_OPEN_DRAIN = 10'h00c;
   localparam logic [9:0] OFS_ANALOG_CFG = 10'h010;
   localparam logic [9:0] OFS_CN_EN_LO = 10'h014;
   localparam logic [9:0] OFS_CN_EN_HI = 10'h018;
   localparam logic [9:0] OFS_PULLUP_LO = 10'h01c;
   localparam logic [9:0] OFS_PULLUP_HI = 10'h020;
   localparam logic [9:0] OFS_OSC_CTRL = 10'h024;
   localparam logic [9:0] OFS_IN_REMAP = 10'h040;
   localparam logic [9:0] OFS_OUT_REMAP = 10'h100;
   localparam int WORD_SHIFT = 2;
   localparam int HALF_WIDTH = 16;

   ////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [31:0] DIRECTION_RESET = 32'hffff_ffff;
   localparam logic [31:0] ANALOG_CFG_RESET = 32'h0000_0000;
   localparam logic [4:0] IN_SEL_RESET = 5'h1f;
   localparam logic [4:0] OUT_SEL_RESET = 5'h00;
   localparam logic LOCK_RESET = 1'b0;
   localparam logic ONE_WAY_RESET = 1'b1;

   ////////////////////////////////////////////////////////////////////////
   // Lock control
   localparam logic [7:0] UNLOCK_KEY1 = 8'h46;
   localparam logic [7:0] UNLOCK_KEY2 = 8'h57;
   localparam int LOCK_BIT = 6;

   ////////////////////////////////////////////////////////////////////////
   // Remap codes
   localparam logic [4:0] IN_SEL_TIE_LOW = 5'h1f;
   localparam logic [4:0] OUT_SEL_NULL = 5'h00;
   localparam logic [4:0] OUT_SEL_COMP1 = 5'h01;
   localparam logic [4:0] OUT_SEL_CAN_TX = 5'h10;
   localparam logic [4:0] OUT_SEL_COMPARE1 = 5'h12;
   localparam logic [4:0] OUT_SEL_COMPARE4 = 5'h15;
   localparam int SEL_W = 5;
   localparam int NUM_CODES = 32;

   typedef enum logic [1:0] {
      KEY_IDLE,
      KEY_FIRST,
      KEY_OPEN
   } iopr_key_t;

endpackage : iopr_pkg

// >>> src/iopr_pin_remap.sv
/*
 * I/O port pin logic: direction, latch, open drain, analog configuration,
 * change notification with pull-up controls, remappable pin multiplexer,
 * remap lock with key sequence, one-way lock and shadow monitoring.
 * Assumes a classic Wishbone master on clk, pads sampled from outside the
 * clock domain, peripherals on clk, and a static one-way configuration bit.
 */
// The address map and register access over Wishbone were left to the implementer.

// What this block does
// R1 - Open-drain bit set: pin only pulls low, released instead of high.
// R2 - Analog configuration resets to zero, so shared pins start analog.
// R3 - Pin level reads return zero for every pin configured analog.
// R4 - Software keeps analog pins as inputs, else own level is converted.
// R5 - Software waits one cycle between port change and port read.
// R6 - Change on up to 21 selected inputs requests an interrupt.
// R7 - Two enable registers give each change pin its own interrupt enable.
// R8 - Two pull-up registers enable each change pin's weak pull-up.
// R9 - Software should disable pull-ups on pins used as digital outputs.
// R10 - Remapping covers up to 26 pins numbered by remappable pin number.
// R11 - Each peripheral input has a 5-bit field picking its source pin.
// R12 - Input and output remapping use separate independent registers.
// R13 - Each remappable pin has a 5-bit field picking its peripheral output.
// R14 - Output code zero leaves the pin under port control.
// R15 - Output codes map comparators, UARTs, SPIs, audio, CAN, compares.
// R16 - Remap writes while locked complete but change nothing.
// R17 - Lock is bit 6 of oscillator control; set blocks remap writes.
// R18 - Lock changes only after writing 0x46 then 0x57 to the low byte.
// R19 - Lock holds its value until changed; one unlock allows many writes.
// R20 - Shadow copies watch remap registers; mismatch requests a reset.
// R21 - One-way configuration set: lock cannot be cleared once set.
// R22 - One-way configuration defaults to set when unprogrammed.
// R23 - Direction one is input, zero is output; all inputs after reset.
// R24 - Level read returns pins, level write updates latch, latch reads latch.
// R25 - An actively driving peripheral takes over the pin's output driver.
// R26 - Input code all ones ties peripheral input low; fields reset so.
// R27 - Output codes naming no peripheral behave as the null code.
// R28 - Lock change without the immediately preceding keys is ignored.
module iopr_pin_remap #(
   parameter int NUM_PINS = 32,
   parameter int NUM_REMAP = 26,
   parameter int NUM_CHANGE = 21,
   parameter int NUM_ANALOG = 16,
   parameter int NUM_PERIPH_IN = 25
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [9:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Pads
   input wire logic [NUM_PINS-1:0] padIn,
   output logic [NUM_PINS-1:0] padOut,
   output logic [NUM_PINS-1:0] padOe,
   output logic [NUM_CHANGE-1:0] weakPullup,
   // Peripherals, outputs and drives indexed by output selection code
   input wire logic [31:0] periphOut,
   input wire logic [31:0] periphDrive,
   output logic [NUM_PERIPH_IN-1:0] periphIn,
   // Configuration word and system requests
   input wire logic oneWayLockCfg,
   output logic changeIrq,
   output logic mismatchReset
);

   typedef logic [iopr_pkg::SEL_W-1:0] iopr_sel_t;

   typedef struct packed {
      logic [NUM_PINS-1:0] direction;
      logic [NUM_PINS-1:0] latch;
      logic [NUM_PINS-1:0] openDrain;
      logic [NUM_ANALOG-1:0] analogCfg;
      logic [NUM_CHANGE-1:0] changeEn;
      logic [NUM_CHANGE-1:0] pullupEn;
      logic [NUM_CHANGE-1:0] changeRef;
      iopr_sel_t [NUM_PERIPH_IN-1:0] inSel;
      iopr_sel_t [NUM_PERIPH_IN-1:0] inShadow;
      iopr_sel_t [NUM_REMAP-1:0] outSel;
      iopr_sel_t [NUM_REMAP-1:0] outShadow;
      logic lock;
      logic oneWay;
      logic cfgCaught;
      iopr_pkg::iopr_key_t keyState;
      logic [NUM_PINS-1:0] padMeta;
      logic [NUM_PINS-1:0] padSync;
      logic [NUM_PINS-1:0] padOut;
      logic [NUM_PINS-1:0] padOe;
      logic [NUM_CHANGE-1:0] weakPullup;
      logic [NUM_PERIPH_IN-1:0] periphIn;
      logic changeIrq;
      logic mismatch;
      logic ack;
      logic [31:0] rdata;
   } iopr_state_t;

   iopr_state_t s;
   iopr_state_t next_s;

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wdata,
                                         input logic [3:0] sel);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[b*8 +: 8] = wdata[b*8 +: 8];
         end
      end
      return res;
   endfunction : merge

   // Codes that name a peripheral output; all others act as null
   function automatic logic codeValid(input iopr_sel_t code);
      return (code >= iopr_pkg::OUT_SEL_COMP1 &&
              code <= iopr_pkg::OUT_SEL_CAN_TX) ||
             (code >= iopr_pkg::OUT_SEL_COMPARE1 &&
              code <= iopr_pkg::OUT_SEL_COMPARE4); // R15 R27
   endfunction : codeValid

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      logic req;
      logic wr;
      logic lowByte;
      logic [31:0] rd;
      logic [NUM_PINS-1:0] digitalMask;
      logic [NUM_PINS-1:0] levelView;
      logic [NUM_CHANGE-1:0] changeHit;
      logic [31:0] hiWord;
      iopr_sel_t code;
      logic periphOwns;
      logic value;
      logic drive;
      req = 1'b0;
      wr = 1'b0;
      lowByte = 1'b0;
      rd = 32'h0000_0000;
      digitalMask = '1;
      levelView = '0;
      changeHit = '0;
      hiWord = 32'h0000_0000;
      code = iopr_pkg::OUT_SEL_NULL;
      periphOwns = 1'b0;
      value = 1'b0;
      drive = 1'b0;
      next_s = s;

      // Pad synchronisers
      next_s.padMeta = padIn;
      next_s.padSync = s.padMeta;

      // Configuration word is taken once, after reset release
      if (!s.cfgCaught) begin
         next_s.cfgCaught = 1'b1;
         next_s.oneWay = oneWayLockCfg; // R21 R22
      end

      // Analog pins read as zero
      for (int i = 0; i < NUM_ANALOG; i++) begin
         digitalMask[i] = s.analogCfg[i];
      end
      levelView = s.padSync & digitalMask; // R3 R24

      // Bus request, answered one cycle after it is seen
      req = wb_cyc_i && wb_stb_i && !s.ack;
      wr = req && wb_we_i;
      lowByte = wr && wb_sel_i[0];
      next_s.ack = req;

      // Read data
      unique case (wb_adr_i)
         iopr_pkg::OFS_DIRECTION: rd = 32'(s.direction);
         iopr_pkg::OFS_LATCH: rd = 32'(s.latch); // R24
         iopr_pkg::OFS_LEVEL: rd = 32'(levelView); // R24
         iopr_pkg::OFS_OPEN_DRAIN: rd = 32'(s.openDrain);
         iopr_pkg::OFS_ANALOG_CFG: rd = 32'(s.analogCfg);
         iopr_pkg::OFS_CN_EN_LO:
            rd = 32'(s.changeEn) & 32'h0000_ffff;
         iopr_pkg::OFS_CN_EN_HI:
            rd = 32'(s.changeEn) >> iopr_pkg::HALF_WIDTH;
         iopr_pkg::OFS_PULLUP_LO:
            rd = 32'(s.pullupEn) & 32'h0000_ffff;
         iopr_pkg::OFS_PULLUP_HI:
            rd = 32'(s.pullupEn) >> iopr_pkg::HALF_WIDTH;
         iopr_pkg::OFS_OSC_CTRL: rd[iopr_pkg::LOCK_BIT] = s.lock;
         default: rd = 32'h0000_0000;
      endcase
      for (int i = 0; i < NUM_PERIPH_IN; i++) begin
         if (wb_adr_i == iopr_pkg::OFS_IN_REMAP +
             10'(i << iopr_pkg::WORD_SHIFT)) begin
            rd = 32'(s.inSel[i]);
         end
      end
      for (int i = 0; i < NUM_REMAP; i++) begin
         if (wb_adr_i == iopr_pkg::OFS_OUT_REMAP +
             10'(i << iopr_pkg::WORD_SHIFT)) begin
            rd = 32'(s.outSel[i]);
         end
      end
      if (req && !wb_we_i) begin
         next_s.rdata = rd;
      end

      // Reading the pin levels re-arms change detection
      if (req && !wb_we_i && wb_adr_i == iopr_pkg::OFS_LEVEL) begin
         next_s.changeRef = s.padSync[NUM_CHANGE-1:0];
      end

      // Port register writes
      if (wr) begin
         unique case (wb_adr_i)
            iopr_pkg::OFS_DIRECTION:
               next_s.direction = NUM_PINS'(merge(32'(s.direction),
                  wb_dat_i, wb_sel_i)); // R23
            iopr_pkg::OFS_LATCH, iopr_pkg::OFS_LEVEL:
               next_s.latch = NUM_PINS'(merge(32'(s.latch),
                  wb_dat_i, wb_sel_i)); // R24
            iopr_pkg::OFS_OPEN_DRAIN:
               next_s.openDrain = NUM_PINS'(merge(32'(s.openDrain),
                  wb_dat_i, wb_sel_i));
            iopr_pkg::OFS_ANALOG_CFG:
               next_s.analogCfg = NUM_ANALOG'(merge(32'(s.analogCfg),
                  wb_dat_i, wb_sel_i));
            iopr_pkg::OFS_CN_EN_LO: begin
               hiWord = merge(32'(s.changeEn), wb_dat_i & 32'h0000_ffff,
                  wb_sel_i & 4'h3);
               next_s.changeEn = NUM_CHANGE'(hiWord); // R7
            end
            iopr_pkg::OFS_CN_EN_HI: begin
               hiWord = merge(32'(s.changeEn) >> iopr_pkg::HALF_WIDTH,
                  wb_dat_i, wb_sel_i);
               next_s.changeEn = NUM_CHANGE'(
                  (hiWord << iopr_pkg::HALF_WIDTH) |
                  (32'(s.changeEn) & 32'h0000_ffff)); // R7
            end
            iopr_pkg::OFS_PULLUP_LO: begin
               hiWord = merge(32'(s.pullupEn), wb_dat_i & 32'h0000_ffff,
                  wb_sel_i & 4'h3);
               next_s.pullupEn = NUM_CHANGE'(hiWord); // R8
            end
            iopr_pkg::OFS_PULLUP_HI: begin
               hiWord = merge(32'(s.pullupEn) >> iopr_pkg::HALF_WIDTH,
                  wb_dat_i, wb_sel_i);
               next_s.pullupEn = NUM_CHANGE'(
                  (hiWord << iopr_pkg::HALF_WIDTH) |
                  (32'(s.pullupEn) & 32'h0000_ffff)); // R8
            end
            default: begin
            end
         endcase
      end

      // Remap writes, acknowledged but dropped while locked
      if (wr && !s.lock) begin // R16 R17 R19
         for (int i = 0; i < NUM_PERIPH_IN; i++) begin
            if (wb_adr_i == iopr_pkg::OFS_IN_REMAP +
                10'(i << iopr_pkg::WORD_SHIFT) && wb_sel_i[0]) begin
               next_s.inSel[i] = wb_dat_i[iopr_pkg::SEL_W-1:0]; // R11 R12
               next_s.inShadow[i] = wb_dat_i[iopr_pkg::SEL_W-1:0];
            end
         end
         for (int i = 0; i < NUM_REMAP; i++) begin
            if (wb_adr_i == iopr_pkg::OFS_OUT_REMAP +
                10'(i << iopr_pkg::WORD_SHIFT) && wb_sel_i[0]) begin
               next_s.outSel[i] = wb_dat_i[iopr_pkg::SEL_W-1:0]; // R13 R12
               next_s.outShadow[i] = wb_dat_i[iopr_pkg::SEL_W-1:0];
            end
         end
      end

      // Lock key sequencer; any other write breaks the sequence
      if (wr) begin
         next_s.keyState = iopr_pkg::KEY_IDLE; // R28
         if (wb_adr_i == iopr_pkg::OFS_OSC_CTRL && lowByte) begin
            case (s.keyState)
               iopr_pkg::KEY_IDLE: begin
                  if (wb_dat_i[7:0] == iopr_pkg::UNLOCK_KEY1) begin
                     next_s.keyState = iopr_pkg::KEY_FIRST; // R18
                  end
               end
               iopr_pkg::KEY_FIRST: begin
                  if (wb_dat_i[7:0] == iopr_pkg::UNLOCK_KEY2) begin
                     next_s.keyState = iopr_pkg::KEY_OPEN; // R18
                  end else if (wb_dat_i[7:0] == iopr_pkg::UNLOCK_KEY1) begin
                     next_s.keyState = iopr_pkg::KEY_FIRST;
                  end
               end
               iopr_pkg::KEY_OPEN: begin
                  if (!(s.oneWay && s.lock)) begin // R21
                     next_s.lock = wb_dat_i[iopr_pkg::LOCK_BIT]; // R17 R18
                  end
               end
               default: next_s.keyState = iopr_pkg::KEY_IDLE;
            endcase
         end
      end

      // Shadow monitoring, held until system reset
      if (s.inSel != s.inShadow || s.outSel != s.outShadow) begin
         next_s.mismatch = 1'b1; // R20
      end

      // Change notification; disabled pins track their level
      for (int j = 0; j < NUM_CHANGE; j++) begin
         if (!s.changeEn[j]) begin
            next_s.changeRef[j] = s.padSync[j];
         end
         changeHit[j] = s.changeEn[j] && (s.padSync[j] != s.changeRef[j]);
      end
      next_s.changeIrq = |changeHit; // R6 R7
      next_s.weakPullup = s.pullupEn; // R8

      // Peripheral inputs from the selected remappable pin
      for (int i = 0; i < NUM_PERIPH_IN; i++) begin
         if (s.inSel[i] < iopr_sel_t'(NUM_REMAP)) begin
            next_s.periphIn[i] = s.padSync[s.inSel[i]]; // R11
         end else begin
            next_s.periphIn[i] = 1'b0; // R26
         end
      end

      // Pad drivers
      for (int i = 0; i < NUM_PINS; i++) begin
         periphOwns = 1'b0;
         value = s.latch[i];
         drive = !s.direction[i]; // R23
         if (i < NUM_REMAP) begin // R10
            code = s.outSel[i];
            periphOwns = codeValid(code) && periphDrive[code]; // R14 R25
         end
         if (periphOwns) begin
            value = periphOut[code]; // R13 R25
            drive = 1'b1;
         end
         if (s.openDrain[i]) begin
            next_s.padOut[i] = 1'b0; // R1
            next_s.padOe[i] = drive && !value; // R1
         end else begin
            next_s.padOut[i] = value;
            next_s.padOe[i] = drive;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
         s.direction <= NUM_PINS'(iopr_pkg::DIRECTION_RESET); // R23
         s.analogCfg <= NUM_ANALOG'(iopr_pkg::ANALOG_CFG_RESET); // R2
         s.inSel <= {NUM_PERIPH_IN{iopr_pkg::IN_SEL_RESET}}; // R26
         s.inShadow <= {NUM_PERIPH_IN{iopr_pkg::IN_SEL_RESET}};
         s.outSel <= {NUM_REMAP{iopr_pkg::OUT_SEL_RESET}};
         s.outShadow <= {NUM_REMAP{iopr_pkg::OUT_SEL_RESET}};
         s.lock <= iopr_pkg::LOCK_RESET;
         s.oneWay <= iopr_pkg::ONE_WAY_RESET; // R22
         s.keyState <= iopr_pkg::KEY_IDLE;
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   assign wb_dat_o = s.rdata;
   assign wb_ack_o = s.ack;
   assign padOut = s.padOut;
   assign padOe = s.padOe;
   assign weakPullup = s.weakPullup;
   assign periphIn = s.periphIn;
   assign changeIrq = s.changeIrq;
   assign mismatchReset = s.mismatch;

endmodule : iopr_pin_remap

// >>> tb/iopr_pin_remap_asserts.sv
/*
 * Port checker of the pin remap block.
 * Assumes pins 26..31 lie outside the remap range.
 */
module iopr_pin_remap_asserts #(
   parameter int NUM_PINS = 32,
   parameter int NUM_CHANGE = 21,
   parameter int NUM_PERIPH_IN = 25
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [9:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // Pads and system
   input wire logic [NUM_PINS-1:0] padIn,
   input wire logic [NUM_PINS-1:0] padOut,
   input wire logic [NUM_PINS-1:0] padOe,
   input wire logic [NUM_CHANGE-1:0] weakPullup,
   input wire logic [NUM_PERIPH_IN-1:0] periphIn,
   input wire logic changeIrq,
   input wire logic mismatchReset
);
   logic take, wr;
   logic [31:0] mask, dirQ, latQ, odcQ, oeExp, outExp;
   logic [NUM_PINS-1:0] padPrev;
   logic [3:0] quiet;
   assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr = take && wb_we_i;
   assign mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}},
      {8{wb_sel_i[0]}}};

   ////////////////////////////////////////////////////////////////////////
   // Shadow of the port registers and cycles since the last pad change
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dirQ <= '1;
         latQ <= '0;
         odcQ <= '0;
         oeExp <= '0;
         outExp <= '0;
         padPrev <= '0;
         quiet <= 4'hf;
      end else begin
         if (wr && wb_adr_i == iopr_pkg::OFS_DIRECTION)
            dirQ <= (dirQ & ~mask) | (wb_dat_i & mask);
         if (wr && (wb_adr_i == iopr_pkg::OFS_LATCH ||
               wb_adr_i == iopr_pkg::OFS_LEVEL))
            latQ <= (latQ & ~mask) | (wb_dat_i & mask);
         if (wr && wb_adr_i == iopr_pkg::OFS_OPEN_DRAIN)
            odcQ <= (odcQ & ~mask) | (wb_dat_i & mask);
         oeExp <= ~dirQ & ~(odcQ & latQ);
         outExp <= latQ & ~odcQ;
         padPrev <= padIn;
         quiet <= (padIn != padPrev) ? 4'h0 : (quiet == 4'hf ? quiet :
            quiet + 4'h1);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_ack_answer: assert property (take |=> wb_ack_o)
      else $error("request not answered next cycle");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_read_hold: assert property ($changed(wb_dat_o) |->
      $past(take && !wb_we_i)) else $error("read data changed idle");
   a_pin_enable: assert property (padOe[31:26] == oeExp[31:26])
      else $error("port drive enable wrong");
   a_pin_value: assert property ((padOut[31:26] & padOe[31:26]) ==
      (outExp[31:26] & oeExp[31:26])) else $error("port value wrong");
   a_reset_quiet: assert property ($rose(rst_n) |-> padOe == '0 &&
      periphIn == '0 && weakPullup == '0 && !changeIrq)
      else $error("outputs not idle after reset");
   a_no_mismatch: assert property (!mismatchReset)
      else $error("mismatch reset in normal operation");
   a_pullup_write: assert property ($changed(weakPullup) |->
      wb_ack_o || $past(wb_ack_o)) else $error("pull-up changed alone");
   a_irq_cause: assert property ($rose(changeIrq) |-> quiet <= 4'h4)
      else $error("change request without pad change");
   cover property (wr && wb_adr_i == iopr_pkg::OFS_OSC_CTRL);
   cover property ($rose(changeIrq));
   cover property ($rose(padOe[1]));
endmodule : iopr_pin_remap_asserts

bind iopr_pin_remap iopr_pin_remap_asserts #(.NUM_PINS(NUM_PINS),
   .NUM_CHANGE(NUM_CHANGE), .NUM_PERIPH_IN(NUM_PERIPH_IN)) i_chk (
   .clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
   .wb_dat_i, .wb_dat_o, .wb_ack_o, .padIn, .padOut, .padOe, .weakPullup,
   .periphIn, .changeIrq, .mismatchReset);

// >>> tb/iopr_far_model.sv
/*
 * Far side: pads, outside drivers, pull-ups and peripherals.
 * Assumes one clock; a floating pad toggles every cycle.
 */
module iopr_far_model (
   // Clock
   input wire logic clk,
   // Block side
   input wire logic [31:0] padOut,
   input wire logic [31:0] padOe,
   input wire logic [20:0] weakPullup,
   output logic [31:0] padIn,
   output logic [31:0] periphOut,
   output logic [31:0] periphDrive,
   // Bench commands
   input wire logic [31:0] extLevel,
   input wire logic [31:0] extDrive,
   input wire logic [31:0] srcOut,
   input wire logic [31:0] srcDrive
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] lastLevel;
   logic [31:0] pull;
   assign pull = {11'h000, weakPullup};
   assign periphOut = srcOut;
   assign periphDrive = srcDrive;
   always_comb begin
      for (int i = 0; i < 32; i++) begin
         padIn[i] = padOe[i] ? padOut[i] : extDrive[i] ? extLevel[i] :
            pull[i] | ~lastLevel[i];
      end
   end
   always_ff @(posedge clk) begin
      lastLevel <= padIn;
   end
endmodule : iopr_far_model

// >>> tb/iopr_pin_remap_tb.sv
/*
 * Bench of the pin remap block: ports, remap codes, locks, change irq.
 * Assumes the far model and the bound checker.
 */
module iopr_pin_remap_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, oneWay = 1'b1, ack, valid;
   logic changeIrq, mismatchReset;
   logic [9:0] adr = 10'h000;
   logic [3:0] sel = 4'hf;
   logic [31:0] datIn = 32'h0, datOut, rd, padIn, padOut, padOe;
   logic [31:0] periphOut, periphDrive, srcOut = 32'h0, srcDrive = 32'h0;
   logic [31:0] extLevel = 32'h0000_ffff, extDrive = 32'hffff_ffff;
   logic [20:0] weakPullup;
   logic [24:0] periphIn;
   int mismatches = 0;
   int checksDone = 0;

   always #12.5 clk = ~clk;

   iopr_pin_remap i_dut (.clk, .rst_n, .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datIn),
      .wb_dat_o(datOut), .wb_ack_o(ack), .padIn, .padOut, .padOe,
      .weakPullup, .periphOut, .periphDrive, .periphIn,
      .oneWayLockCfg(oneWay), .changeIrq, .mismatchReset);
   iopr_far_model i_far (.clk, .padOut, .padOe, .weakPullup, .padIn,
      .periphOut, .periphDrive, .extLevel, .extDrive, .srcOut, .srcDrive);

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checksDone++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic conclude;
      $display("Checks %0d, mismatches %0d", checksDone, mismatches);
      if (mismatches == 0 && checksDone > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : conclude

   task automatic access(input logic w, input logic [9:0] a,
         input logic [31:0] d);
      int n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      datIn <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      rd = datOut;
      check(32'(ack), 32'h1);
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : access

   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      access(1'b1, a, d);
   endtask : wr

   task automatic rdChk(input logic [9:0] a, input logic [31:0] exp);
      access(1'b0, a, 32'h0);
      check(rd, exp);
   endtask : rdChk

   task automatic pause(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask : pause

   task automatic setLock(input logic v);
      wr(iopr_pkg::OFS_OSC_CTRL, 32'h46);
      wr(iopr_pkg::OFS_OSC_CTRL, 32'h57);
      wr(iopr_pkg::OFS_OSC_CTRL, {25'h0, v, 6'h0});
   endtask : setLock

   task automatic resetDut(input logic ow);
      @(posedge clk);
      oneWay <= ow;
      rst_n <= 1'b0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
   endtask : resetDut

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      $display("Error at %0t: run did not finish", $time);
      conclude();
   end

   initial begin
      resetDut(1'b1);
      rdChk(iopr_pkg::OFS_DIRECTION, 32'hffff_ffff);
      rdChk(iopr_pkg::OFS_ANALOG_CFG, 32'h0);
      rdChk(iopr_pkg::OFS_IN_REMAP, 32'h1f);
      rdChk(iopr_pkg::OFS_OUT_REMAP, 32'h0);
      rdChk(10'h3fc, 32'h0);
      // Pins 26..31 out, pin 30 open drain
      wr(iopr_pkg::OFS_DIRECTION, 32'h03ff_ffff);
      wr(iopr_pkg::OFS_OPEN_DRAIN, 32'h4000_0000);
      wr(iopr_pkg::OFS_LEVEL, 32'h5000_0000);
      rdChk(iopr_pkg::OFS_LATCH, 32'h5000_0000);
      pause(1);
      check(padOe & 32'hfc00_0000, 32'hbc00_0000);
      check(padOut & 32'hfc00_0000, 32'h1000_0000);
      rdChk(iopr_pkg::OFS_LEVEL, 32'h1000_0000);
      wr(iopr_pkg::OFS_ANALOG_CFG, 32'h0000_ffff);
      rdChk(iopr_pkg::OFS_LEVEL, 32'h1000_ffff);
      // Every output code on remappable pin 1
      @(posedge clk);
      srcOut <= 32'haaaa_5555;
      srcDrive <= 32'hffff_ffff;
      for (int c = 0; c < 32; c++) begin
         wr(iopr_pkg::OFS_OUT_REMAP + 10'h004, c[31:0]);
         pause(1);
         valid = (c >= 1 && c <= 16) || (c >= 18 && c <= 21);
         check(32'(padOe[1]), 32'(valid));
         if (valid) check(32'(padOut[1]), 32'(srcOut[c]));
      end
      wr(iopr_pkg::OFS_OUT_REMAP + 10'h004, 32'h03);
      srcDrive <= 32'h0;
      pause(2);
      check(32'(padOe[1]), 32'h0);
      // Input field 0 from pad 5
      wr(iopr_pkg::OFS_IN_REMAP, 32'h05);
      pause(4);
      check(32'(periphIn[0]), 32'h1);
      wr(iopr_pkg::OFS_IN_REMAP, 32'h1f);
      pause(4);
      check(32'(periphIn[0]), 32'h0);
      wr(iopr_pkg::OFS_IN_REMAP, 32'h05);
      @(posedge clk);
      extLevel <= 32'h0000_ffdf;
      pause(4);
      check(32'(periphIn[0]), 32'h0);
      // Lock with one-way set
      setLock(1'b1);
      rdChk(iopr_pkg::OFS_OSC_CTRL, 32'h40);
      wr(iopr_pkg::OFS_OUT_REMAP, 32'h03);
      rdChk(iopr_pkg::OFS_OUT_REMAP, 32'h0);
      wr(iopr_pkg::OFS_IN_REMAP, 32'h1f);
      rdChk(iopr_pkg::OFS_IN_REMAP, 32'h05);
      wr(iopr_pkg::OFS_OSC_CTRL, 32'h0);
      rdChk(iopr_pkg::OFS_OSC_CTRL, 32'h40);
      setLock(1'b0);
      rdChk(iopr_pkg::OFS_OSC_CTRL, 32'h40);
      // Reset with one-way clear
      resetDut(1'b0);
      rdChk(iopr_pkg::OFS_OUT_REMAP + 10'h004, 32'h0);
      wr(iopr_pkg::OFS_OSC_CTRL, 32'h46);
      wr(iopr_pkg::OFS_LATCH, 32'h0);
      wr(iopr_pkg::OFS_OSC_CTRL, 32'h57);
      wr(iopr_pkg::OFS_OSC_CTRL, 32'h40);
      rdChk(iopr_pkg::OFS_OSC_CTRL, 32'h0);
      setLock(1'b1);
      setLock(1'b0);
      rdChk(iopr_pkg::OFS_OSC_CTRL, 32'h0);
      wr(iopr_pkg::OFS_OUT_REMAP + 10'h008, 32'h03);
      wr(iopr_pkg::OFS_OUT_REMAP + 10'h00c, 32'h07);
      rdChk(iopr_pkg::OFS_OUT_REMAP + 10'h008, 32'h03);
      rdChk(iopr_pkg::OFS_OUT_REMAP + 10'h00c, 32'h07);
      // Change notification
      wr(iopr_pkg::OFS_PULLUP_HI, 32'h1);
      pause(1);
      check(32'(weakPullup), 32'h0001_0000);
      wr(iopr_pkg::OFS_CN_EN_HI, 32'h2);
      rdChk(iopr_pkg::OFS_LEVEL, 32'h0);
      @(posedge clk);
      extLevel[18] <= 1'b1;
      extDrive[16] <= 1'b0;
      pause(5);
      check(32'(changeIrq), 32'h0);
      @(posedge clk);
      extLevel[17] <= 1'b1;
      pause(5);
      check(32'(changeIrq), 32'h1);
      rdChk(iopr_pkg::OFS_LEVEL, 32'h0007_0000);
      pause(2);
      check(32'(changeIrq), 32'h0);
      conclude();
   end
endmodule : iopr_pin_remap_tb
